// >>> verilog/tlf_formatter.sv
// tlf_formatter: formats cpu trace records into 20-bit lines of a
// circular 64-line trace store, with line count and word readout.
// assumes: all inputs synchronous to CLK; cpu event strobes are
// one-cycle pulses; register port reads answer one cycle later.
// assumes: CE low freezes every register, the store and read data.
// assumes: software reads the low word before the upper word.
// assumes: dedup mode stores like normal mode, with no filtering.
// assumes: held increments stay pending while tracing is off.
// assumes: readout is not locked while tracing runs.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tlf_formatter
    import tlf_pkg::*;
#(
    parameter int DEPTH = TLF_DEPTH
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    // register port
    input wire logic [TLF_AW-1:0] REG_ADDR,
    input wire logic [TLF_DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [TLF_DATA_W-1:0] REG_RDATA,
    // change-of-flow records
    input wire logic COF_VALID,
    input wire logic [TLF_PC_W-1:0] COF_PC,
    input wire logic COF_DEST,
    input wire logic COF_VECTOR,
    // detail access records
    input wire logic ACC_VALID,
    input wire logic [TLF_PC_W-1:0] ACC_ADDR,
    input wire logic [TLF_DATA_W-1:0] ACC_DATA,
    input wire logic ACC_BYTE,
    input wire logic ACC_READ,
    // executed opcode records
    input wire logic OPC_VALID,
    input wire logic [TLF_PC_W-1:0] OPC_PC
);

    // flow and detail lines share this shape; compressed lines
    // are built from the format code, the opcode pc and the holding register
    // builds a line from the upper field and two bytes
    function automatic logic [TLF_LINE_W-1:0] fn_line(
        input logic [3:0] hi,
        input logic [7:0] mid,
        input logic [7:0] lo
    );
        fn_line = {hi, mid, lo};
    endfunction

    // register map, one 16-bit word per index:
    //   0 control: bit 0 enable, bits 2:1 mode
    //   1 count: bits 6:0 lines, bit 7 wrapped
    //   2 low word of the line at the read pointer
    //   3 upper field of that line; read steps the pointer
    //   4 pointer: write rewinds to oldest, read shows it
    // enabling from off starts a fresh session: count,
    // pointers and held increments go back to zero, base marked invalid.
    // register file state
    logic [2:0] ctrl_reg; // enable and mode
    logic [TLF_PTR_W-1:0] wr_ptr_reg; // next line to write
    logic [TLF_PTR_W-1:0] rd_ptr_reg; // next line to read out
    logic [TLF_CNT_W-1:0] trace_line_count_reg; // stored lines
    logic wrapped_reg; // writing has passed the last line
    logic [TLF_DATA_W-1:0] rdata_reg; // read answer

    // a compressed line grows in hold_reg until three
    // increments are in or a new base forces it out early;
    // a part line's format code is its increment count.
    // compressed mode state
    logic [TLF_PC_W-1:0] hold_reg; // pending increments
    logic [1:0] hold_cnt_reg; // increments held, 0..2
    logic [TLF_PC_W-1:TLF_INC_W] base_reg; // current base pc 17:6
    logic base_valid_reg; // a base line has been stored

    // no reset on the store: a session taken before a
    // reset can still be read back after it; lines never
    // written read as unknown.
    // trace store
    logic [TLF_LINE_W-1:0] mem [DEPTH];

    // a session starts only on the edge from off to on, so
    // rewriting the mode while enabled keeps the trace.
    // decoded control
    tlf_mode_t mode;
    logic trace_on;
    logic ctrl_wr;
    logic session_start;
    logic ptr_wr;
    logic tbhi_rd;

    // detail mode and a flush ahead of a base both need two
    // lines in one edge; slot 1 always lands on wr_ptr + 1.
    // write slots: slot 1 goes to the line after slot 0
    logic wr0_en;
    logic wr1_en;
    logic [TLF_LINE_W-1:0] wr0_data;
    logic [TLF_LINE_W-1:0] wr1_data;
    logic [TLF_PTR_W-1:0] wr1_idx;
    logic [1:0] n_lines;
    logic need_base;
    logic [TLF_LINE_W-1:0] partial_line;
    logic [TLF_PTR_W:0] ptr_sum;
    logic [TLF_CNT_W:0] cnt_sum;

    // the port never carries a write and a read together;
    // writes act at their strobe edge.
    // control decode
    assign mode = tlf_mode_t'(ctrl_reg[TLF_CTRL_MODE_LSB +: 2]);
    assign trace_on = ctrl_reg[TLF_CTRL_EN_BIT];
    assign ctrl_wr = CE && REG_WR && (REG_ADDR == TLF_REG_CTRL);
    assign session_start = ctrl_wr && REG_WDATA[TLF_CTRL_EN_BIT] && !trace_on;
    assign ptr_wr = CE && REG_WR && (REG_ADDR == TLF_REG_RDPTR);
    assign tbhi_rd = CE && REG_RD && (REG_ADDR == TLF_REG_TBHI);

    // the line-0 term catches a wrap: a base written at the
    // last line leaves the holding empty, so the next opcode
    // lands a base on line 0 as well.
    // a new base is due on first line, on block change, or at line 0
    assign need_base = !base_valid_reg
        || (OPC_PC[TLF_PC_W-1:TLF_INC_W] != base_reg)
        || (hold_cnt_reg == 2'h0 && wr_ptr_reg == '0);

    // unused fields are already zero, so a part line needs
    // no masking when it is flushed.
    // partial line: format code equals number of held increments
    assign partial_line = {hold_cnt_reg, hold_reg};

    // wr1_idx wraps with the store, like the pointer sum
    assign wr1_idx = wr_ptr_reg + TLF_PTR_W'(1);
    assign n_lines = {1'b0, wr0_en} + {1'b0, wr1_en};

    // line assembly for the active mode
    always_comb begin
        wr0_en = 1'b0;
        wr1_en = 1'b0;
        wr0_data = '0;
        wr1_data = '0;
        // nothing is stored while disabled or frozen by CE;
        // records of another mode than the active one drop
        if (CE && trace_on) begin
            case (mode)
                // both flow modes share one layout
                TLF_MODE_NORMAL, TLF_MODE_DEDUP: begin
                    if (COF_VALID) begin
                        wr0_en = 1'b1;
                        // vector implies destination
                        wr0_data = fn_line({COF_DEST | COF_VECTOR, COF_VECTOR,
                            COF_PC[17:16]}, COF_PC[15:8], COF_PC[7:0]);
                    end
                end
                // address line then data line
                TLF_MODE_DETAIL: begin
                    if (ACC_VALID) begin
                        wr0_en = 1'b1;
                        wr1_en = 1'b1;
                        // size, direction, address 17:16
                        wr0_data = fn_line({ACC_BYTE, ACC_READ, ACC_ADDR[17:16]},
                            ACC_ADDR[15:8], ACC_ADDR[7:0]);
                        // byte: high cleared; word: lower address in byte1
                        wr1_data = fn_line(4'h0,
                            ACC_BYTE ? 8'h00 : ACC_DATA[15:8],
                            ACC_DATA[7:0]);
                    end
                end
                // compressed lines, no flow flags here
                TLF_MODE_COMPRESSED: begin
                    if (OPC_VALID) begin
                        if (need_base) begin
                            // flush partial line ahead of the base
                            if (hold_cnt_reg != 2'h0) begin
                                wr0_en = 1'b1;
                                wr1_en = 1'b1;
                                wr0_data = partial_line;
                                wr1_data = {TLF_FMT_BASE, OPC_PC};
                            end else begin
                                wr0_en = 1'b1;
                                wr0_data = {TLF_FMT_BASE, OPC_PC};
                            end
                        end else if (hold_cnt_reg == 2'h2) begin
                            // third increment fills the line
                            wr0_en = 1'b1;
                            wr0_data = {TLF_FMT_THREE, OPC_PC[5:0], hold_reg[11:0]};
                        end
                    end
                end
                default: begin
                    wr0_en = 1'b0;
                end
            endcase
        end
    end

    // a mode change inside a session clears nothing;
    // software restarts the session to begin afresh
    // control register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_reg <= TLF_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= REG_WDATA[2:0];
        end
    end

    // wrapped_reg stays set for the session once the pointer
    // has passed the last line; it also picks the oldest line
    // write pointer, wraps around the store
    assign ptr_sum = {1'b0, wr_ptr_reg} + {{(TLF_PTR_W-1){1'b0}}, n_lines};
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ptr_reg <= '0;
            wrapped_reg <= 1'b0;
        end else if (session_start) begin
            // new session starts at line 0
            wr_ptr_reg <= '0;
            wrapped_reg <= 1'b0;
        end else if (n_lines != 2'h0) begin
            wr_ptr_reg <= ptr_sum[TLF_PTR_W-1:0];
            if (ptr_sum[TLF_PTR_W]) begin
                wrapped_reg <= 1'b1;
            end
        end
    end

    // the count never falls as lines are read out, and it
    // saturates so software sees at most a full store
    // line count, one per line, two per detail access
    assign cnt_sum = {1'b0, trace_line_count_reg} + {{(TLF_CNT_W-1){1'b0}}, n_lines};
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trace_line_count_reg <= '0;
        end else if (session_start) begin
            trace_line_count_reg <= '0;
        end else if (n_lines != 2'h0) begin
            // holds at the store depth once full
            if (cnt_sum >= (TLF_CNT_W+1)'(DEPTH)) begin
                trace_line_count_reg <= TLF_CNT_W'(DEPTH);
            end else begin
                trace_line_count_reg <= cnt_sum[TLF_CNT_W-1:0];
            end
        end
    end

    // the base tracks pc 17:6 of the last base line; a flush
    // and a base in one edge leave the holding empty
    // compressed holding register and base tracking
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hold_reg <= '0;
            hold_cnt_reg <= 2'h0;
            base_reg <= '0;
            base_valid_reg <= 1'b0;
        end else if (session_start) begin
            // first line of a session is a base
            hold_reg <= '0;
            hold_cnt_reg <= 2'h0;
            base_valid_reg <= 1'b0;
        end else if (CE && trace_on && mode == TLF_MODE_COMPRESSED && OPC_VALID) begin
            if (need_base) begin
                // base line written, holding emptied
                hold_reg <= '0;
                hold_cnt_reg <= 2'h0;
                base_reg <= OPC_PC[TLF_PC_W-1:TLF_INC_W];
                base_valid_reg <= 1'b1;
            end else if (hold_cnt_reg == 2'h2) begin
                // line committed, unused fields back to zero
                hold_reg <= '0;
                hold_cnt_reg <= 2'h0;
            end else begin
                // increment is the offset in the 64-address range
                hold_reg[hold_cnt_reg*TLF_INC_W +: TLF_INC_W] <= OPC_PC[5:0];
                hold_cnt_reg <= hold_cnt_reg + 2'h1;
            end
        end
    end

    // slot 0 would win if both slots aimed at one line,
    // which the pointer arithmetic never allows
    // trace store lines, not reset: contents survive a reset
    for (genvar i = 0; i < DEPTH; i++) begin : g_line
        always_ff @(posedge CLK) begin
            if (wr0_en && wr_ptr_reg == TLF_PTR_W'(i)) begin
                mem[i] <= wr0_data;
            end else if (wr1_en && wr1_idx == TLF_PTR_W'(i)) begin
                // second line of a pair
                mem[i] <= wr1_data;
            end
        end
    end

    // only the upper word steps the pointer, so the low
    // word alone can be read again safely
    // readout pointer
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_ptr_reg <= '0;
        end else if (session_start) begin
            rd_ptr_reg <= '0;
        end else if (ptr_wr) begin
            // restart at the oldest line, wrapped or not
            rd_ptr_reg <= wrapped_reg ? wr_ptr_reg : '0;
        end else if (tbhi_rd) begin
            // upper word closes the line
            rd_ptr_reg <= rd_ptr_reg + TLF_PTR_W'(1);
        end
    end

    // while CE is high the answer stands one cycle and is zero otherwise,
    // so a stale word is never taken for a fresh one
    // read answer, one cycle after the strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= '0;
        end else if (CE) begin
            rdata_reg <= '0;
            if (REG_RD) begin
                case (REG_ADDR)
                    TLF_REG_CTRL: begin
                        rdata_reg <= {13'h0000, ctrl_reg};
                    end
                    TLF_REG_COUNT: begin
                        rdata_reg <= {8'h00, wrapped_reg, trace_line_count_reg};
                    end
                    // low 16 bits first
                    TLF_REG_TBLO: begin
                        rdata_reg <= mem[rd_ptr_reg][15:0];
                    end
                    // upper field, bits 15:4 zero
                    TLF_REG_TBHI: begin
                        rdata_reg <= {12'h000, mem[rd_ptr_reg][19:16]};
                    end
                    TLF_REG_RDPTR: begin
                        rdata_reg <= {10'h000, rd_ptr_reg};
                    end
                    // unmapped reads as zero
                    default: begin
                        rdata_reg <= '0;
                    end
                endcase
            end
        end
    end

    // read data straight from a flop, no decode after it
    assign REG_RDATA = rdata_reg;

endmodule // tlf_formatter

// >>> verilog/tlf_pkg.sv
// tlf_pkg: constants and types for the trace line formatter.
// assumes: one clock, a plain register port with 3-bit word index.
package tlf_pkg;
    // trace store geometry
    localparam int TLF_DEPTH = 64;
    localparam int TLF_LINE_W = 20;
    localparam int TLF_PTR_W = 6;
    localparam int TLF_CNT_W = 7;
    localparam int TLF_PC_W = 18;
    localparam int TLF_DATA_W = 16;
    localparam int TLF_AW = 3;
    // register indices
    localparam logic [2:0] TLF_REG_CTRL = 3'h0;
    localparam logic [2:0] TLF_REG_COUNT = 3'h1;
    localparam logic [2:0] TLF_REG_TBLO = 3'h2;
    localparam logic [2:0] TLF_REG_TBHI = 3'h3;
    localparam logic [2:0] TLF_REG_RDPTR = 3'h4;
    // control fields and reset value
    localparam int TLF_CTRL_EN_BIT = 0;
    localparam int TLF_CTRL_MODE_LSB = 1;
    localparam logic [2:0] TLF_CTRL_RST = 3'h0;
    // count register: wrap flag position
    localparam int TLF_COUNT_WRAP_BIT = 7;
    // compressed field width and line format codes
    localparam int TLF_INC_W = 6;
    localparam logic [1:0] TLF_FMT_BASE = 2'h0;
    localparam logic [1:0] TLF_FMT_THREE = 2'h3;
    // trace modes, in control register encoding order
    typedef enum logic [1:0] {
        TLF_MODE_NORMAL,
        TLF_MODE_DEDUP,
        TLF_MODE_DETAIL,
        TLF_MODE_COMPRESSED
    } tlf_mode_t;
endpackage

// >>> verification/tlf_formatter_checker.sv
// checker: port-level properties of tlf_formatter, bound at the foot.
// assumes: one clock CLK, RESET_N asynchronous and active low.
`timescale 1ns/1ps
module tlf_formatter_checker
    import tlf_pkg::*;
#(
    parameter int DEPTH = TLF_DEPTH
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic [TLF_AW-1:0] REG_ADDR,
    input wire logic [TLF_DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [TLF_DATA_W-1:0] REG_RDATA,
    input wire logic COF_VALID,
    input wire logic [TLF_PC_W-1:0] COF_PC,
    input wire logic COF_DEST,
    input wire logic COF_VECTOR,
    input wire logic ACC_VALID,
    input wire logic [TLF_PC_W-1:0] ACC_ADDR,
    input wire logic [TLF_DATA_W-1:0] ACC_DATA,
    input wire logic ACC_BYTE,
    input wire logic ACC_READ,
    input wire logic OPC_VALID,
    input wire logic [TLF_PC_W-1:0] OPC_PC
);
    logic en_reg; // enable as last written
    logic [1:0] mode_reg; // mode as last written
    logic [6:0] cnt_reg; // expected line count
    logic cnt_ok_reg; // low once compressed lines make the count untracked
    wire logic cof_hit = en_reg && !mode_reg[1] && COF_VALID;
    wire logic acc_hit = en_reg && mode_reg == TLF_MODE_DETAIL && ACC_VALID;
    wire logic [7:0] cnt_next = {1'b0, cnt_reg} + {7'h0, cof_hit} + {6'h0, acc_hit, 1'b0};
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // shadow of control writes and of counted records
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            en_reg <= 1'b0;
            mode_reg <= 2'h0;
            cnt_reg <= 7'h0;
            cnt_ok_reg <= 1'b1;
        end else if (CE && REG_WR && REG_ADDR == TLF_REG_CTRL) begin
            en_reg <= REG_WDATA[0];
            mode_reg <= REG_WDATA[2:1];
            // a new session clears the count
            if (REG_WDATA[0] && !en_reg) begin
                cnt_reg <= 7'h0;
                cnt_ok_reg <= 1'b1;
            end
        end else if (CE) begin
            cnt_reg <= (cnt_next > 8'(DEPTH)) ? 7'(DEPTH) : cnt_next[6:0];
            if (en_reg && mode_reg == TLF_MODE_COMPRESSED && OPC_VALID) begin
                cnt_ok_reg <= 1'b0;
            end
        end
    end
    sequence s_rd(logic [2:0] a);
        CE && REG_RD && REG_ADDR == a;
    endsequence
    sequence s_start;
        CE && REG_WR && REG_ADDR == TLF_REG_CTRL && REG_WDATA[0] && !en_reg;
    endsequence
    sequence s_quiet_ctrl_rd;
        s_rd(TLF_REG_CTRL) ##0 !(COF_VALID || ACC_VALID || OPC_VALID);
    endsequence
    property p_rdata_idle;
        $past(CE) && !$past(REG_RD) |-> REG_RDATA == 16'h0;
    endproperty
    property p_tbhi_zero;
        s_rd(TLF_REG_TBHI) |=> REG_RDATA[15:4] == 12'h0;
    endproperty
    property p_count_max;
        s_rd(TLF_REG_COUNT) |=> REG_RDATA[6:0] <= 7'(DEPTH) && REG_RDATA[15:8] == 8'h0;
    endproperty
    property p_count_track;
        s_rd(TLF_REG_COUNT) ##0 cnt_ok_reg |=> REG_RDATA[6:0] == $past(cnt_reg);
    endproperty
    property p_session_clear;
        s_start ##1 s_quiet_ctrl_rd ##1 s_rd(TLF_REG_COUNT) |=> REG_RDATA[6:0] == 7'h0;
    endproperty
    property p_ptr_step;
        s_rd(TLF_REG_RDPTR) ##1 s_rd(TLF_REG_TBHI) ##1 s_rd(TLF_REG_RDPTR)
            |=> REG_RDATA[5:0] == $past(REG_RDATA[5:0], 2) + 6'h1;
    endproperty
    property p_unmapped;
        CE && REG_RD && REG_ADDR > TLF_REG_RDPTR |=> REG_RDATA == 16'h0;
    endproperty
    property p_ctrl_back;
        CE && REG_WR && REG_ADDR == TLF_REG_CTRL ##1 s_rd(TLF_REG_CTRL)
            |=> REG_RDATA == {13'h0, $past(REG_WDATA[2:0], 2)};
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
    a_tbhi_zero: assert property (p_tbhi_zero) else $error("upper word high bits set");
    a_count_max: assert property (p_count_max) else $error("count above depth");
    a_count_track: assert property (p_count_track) else $error("count wrong");
    a_session_clear: assert property (p_session_clear) else $error("count not cleared");
    a_ptr_step: assert property (p_ptr_step) else $error("read pointer step wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
endmodule // tlf_formatter_checker

bind tlf_formatter tlf_formatter_checker #(.DEPTH(DEPTH)) tlf_formatter_checker_i (
    .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .COF_VALID(COF_VALID),
    .COF_PC(COF_PC), .COF_DEST(COF_DEST), .COF_VECTOR(COF_VECTOR), .ACC_VALID(ACC_VALID),
    .ACC_ADDR(ACC_ADDR), .ACC_DATA(ACC_DATA), .ACC_BYTE(ACC_BYTE), .ACC_READ(ACC_READ),
    .OPC_VALID(OPC_VALID), .OPC_PC(OPC_PC));

// >>> verification/tlf_cpu_model.sv
// tlf_cpu_model: cpu side source of trace records, one cycle each.
// assumes: tasks are called by the bench at or just after a clock edge.
`timescale 1ns/1ps
module tlf_cpu_model
    import tlf_pkg::*;
(
    input wire logic clk,
    output logic cof_valid = 1'b0,
    output logic [17:0] cof_pc = 18'h0,
    output logic cof_dest = 1'b0,
    output logic cof_vector = 1'b0,
    output logic acc_valid = 1'b0,
    output logic [17:0] acc_addr = 18'h0,
    output logic [15:0] acc_data = 16'h0,
    output logic acc_byte = 1'b0,
    output logic acc_read = 1'b0,
    output logic opc_valid = 1'b0,
    output logic [17:0] opc_pc = 18'h0
);
    // change of flow; qualifiers flip once the strobe drops
    task cof(input logic [17:0] pc, input logic dst, input logic vec);
        @(posedge clk);
        {cof_valid, cof_pc, cof_dest, cof_vector} <= {1'b1, pc, dst, vec};
        @(posedge clk);
        {cof_valid, cof_pc, cof_dest, cof_vector} <= {1'b0, ~pc, ~dst, ~vec};
    endtask
    // data access record
    task acc(input logic [17:0] a, input logic [15:0] d, input logic b, input logic r);
        @(posedge clk);
        {acc_valid, acc_addr, acc_data, acc_byte, acc_read} <= {1'b1, a, d, b, r};
        @(posedge clk);
        {acc_valid, acc_addr, acc_data, acc_byte, acc_read} <= {1'b0, ~a, ~d, ~b, ~r};
    endtask
    // executed opcode record
    task opc(input logic [17:0] pc);
        @(posedge clk);
        {opc_valid, opc_pc} <= {1'b1, pc};
        @(posedge clk);
        {opc_valid, opc_pc} <= {1'b0, ~pc};
    endtask
endmodule // tlf_cpu_model

// >>> verification/tb_trace_line_formatter.sv
// tb_trace_line_formatter: self-checking bench of the trace formatter.
// assumes: tlf_cpu_model feeds records; checker is bound in its own file.
`timescale 1ns/1ps
`define CHECK_EQ(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_trace_line_formatter
    import tlf_pkg::*;
;
    typedef struct packed {
        tlf_mode_t m;
        logic [17:0] a;
        logic [15:0] dat;
        logic [1:0] f;
        logic [19:0] l0;
        logic [19:0] l1;
    } tlf_row_t;
    tlf_row_t rows [5] = '{
        '{TLF_MODE_NORMAL, 18'h2ABCD, 16'h0, 2'h0, 20'h2ABCD, 20'h0},
        '{TLF_MODE_NORMAL, 18'h1F00E, 16'h0, 2'h2, 20'h9F00E, 20'h0},
        '{TLF_MODE_DEDUP, 18'h0FFF2, 16'h0, 2'h1, 20'hCFFF2, 20'h0},
        '{TLF_MODE_DETAIL, 18'h31234, 16'hAB5C, 2'h3, 20'hF1234, 20'h0005C},
        '{TLF_MODE_DETAIL, 18'h08001, 16'h1234, 2'h0, 20'h08001, 20'h01234}};
    logic [17:0] cpc [9] = '{18'h20040, 18'h20042, 18'h20044, 18'h20046, 18'h20047,
        18'h20080, 18'h20081, 18'h20082, 18'h300C0};
    logic [19:0] cln [6] = '{20'h20040, 20'hC6102, 20'h40007, 20'h20080, 20'h80081, 20'h300C0};
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [2:0] REG_ADDR = 3'h0;
    logic [15:0] REG_WDATA = 16'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic CE = 1'b1;
    logic [15:0] REG_RDATA, d;
    logic [19:0] ln;
    logic COF_VALID, COF_DEST, COF_VECTOR, ACC_VALID, ACC_BYTE, ACC_READ, OPC_VALID;
    logic [17:0] COF_PC, ACC_ADDR, OPC_PC;
    logic [15:0] ACC_DATA;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    tlf_formatter #(.DEPTH(TLF_DEPTH)) tlf_formatter_i (.CLK(CLK), .RESET_N(RESET_N),
        .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .COF_VALID(COF_VALID), .COF_PC(COF_PC),
        .COF_DEST(COF_DEST), .COF_VECTOR(COF_VECTOR), .ACC_VALID(ACC_VALID),
        .ACC_ADDR(ACC_ADDR), .ACC_DATA(ACC_DATA), .ACC_BYTE(ACC_BYTE), .ACC_READ(ACC_READ),
        .OPC_VALID(OPC_VALID), .OPC_PC(OPC_PC));
    tlf_cpu_model tlf_cpu_model_i (.clk(CLK), .cof_valid(COF_VALID), .cof_pc(COF_PC),
        .cof_dest(COF_DEST), .cof_vector(COF_VECTOR), .acc_valid(ACC_VALID),
        .acc_addr(ACC_ADDR), .acc_data(ACC_DATA), .acc_byte(ACC_BYTE),
        .acc_read(ACC_READ), .opc_valid(OPC_VALID), .opc_pc(OPC_PC));
    // 50 MHz clock and a hang limit
    always #10 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 6000) begin
            errors++;
            summarize();
        end
    end
    task summarize;
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // register port: one-cycle strobes, read data one cycle later
    task wr(input logic [2:0] a, input logic [15:0] v);
        {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, v};
        @(posedge CLK);
        REG_WR <= 1'b0;
        #1;
    endtask
    task rd(input logic [2:0] a, output logic [15:0] v);
        {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 v = REG_RDATA;
    endtask
    task rdline(output logic [19:0] l);
        logic [15:0] lo, hi;
        rd(TLF_REG_TBLO, lo);
        rd(TLF_REG_TBHI, hi);
        l = {hi[3:0], lo};
    endtask
    task start(input tlf_mode_t m);
        wr(TLF_REG_CTRL, 16'h0);
        wr(TLF_REG_CTRL, {13'h0, m, 1'b1});
        rd(TLF_REG_CTRL, d);
        rd(TLF_REG_COUNT, d);
        `CHECK_EQ(d, 16'h0)
    endtask
    initial begin
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        rd(TLF_REG_CTRL, d);
        `CHECK_EQ(d, 16'h0)
        rd(TLF_REG_COUNT, d);
        `CHECK_EQ(d, 16'h0)
        $display("test reset done");
        // ordinary single records, one session each
        foreach (rows[i]) begin
            start(rows[i].m);
            case (rows[i].m)
                TLF_MODE_DETAIL: tlf_cpu_model_i.acc(rows[i].a, rows[i].dat, rows[i].f[1], rows[i].f[0]);
                TLF_MODE_COMPRESSED: tlf_cpu_model_i.opc(rows[i].a);
                default: tlf_cpu_model_i.cof(rows[i].a, rows[i].f[1], rows[i].f[0]);
            endcase
            rd(TLF_REG_COUNT, d);
            `CHECK_EQ(d, (rows[i].m == TLF_MODE_DETAIL) ? 16'h2 : 16'h1)
            wr(TLF_REG_RDPTR, 16'h0);
            rdline(ln);
            `CHECK_EQ(ln, rows[i].l0)
            if (rows[i].m == TLF_MODE_DETAIL) begin
                rdline(ln);
                `CHECK_EQ(ln, rows[i].l1)
            end
            $display("test row %0d done", i);
        end
        // compressed packing, all four formats, foreign records ignored
        start(TLF_MODE_COMPRESSED);
        tlf_cpu_model_i.cof(18'h00123, 1'b1, 1'b0);
        tlf_cpu_model_i.acc(18'h00456, 16'h7777, 1'b0, 1'b1);
        foreach (cpc[i]) tlf_cpu_model_i.opc(cpc[i]);
        rd(TLF_REG_COUNT, d);
        `CHECK_EQ(d, 16'h6)
        wr(TLF_REG_RDPTR, 16'h0);
        foreach (cln[i]) begin
            rdline(ln);
            `CHECK_EQ(ln, cln[i])
        end
        $display("test compressed done");
        // normal mode wrap: oldest line first, pointer steps by one
        start(TLF_MODE_NORMAL);
        for (int i = 0; i < 66; i++) tlf_cpu_model_i.cof(18'(i), 1'b0, 1'b0);
        rd(TLF_REG_COUNT, d);
        `CHECK_EQ(d, 16'h00C0)
        wr(TLF_REG_RDPTR, 16'h0);
        rd(TLF_REG_RDPTR, d);
        `CHECK_EQ(d, 16'h2)
        rdline(ln);
        `CHECK_EQ(ln, 20'h00002)
        rd(TLF_REG_RDPTR, d);
        rd(TLF_REG_TBHI, d);
        rd(TLF_REG_RDPTR, d);
        `CHECK_EQ(d, 16'h4)
        rd(3'h5, d);
        `CHECK_EQ(d, 16'h0)
        $display("test wrap done");
        // compressed wrap: line 0 gets a base even inside the same range
        start(TLF_MODE_COMPRESSED);
        for (int i = 0; i < 63; i++) tlf_cpu_model_i.opc(18'(i * 64));
        for (int i = 1; i < 5; i++) tlf_cpu_model_i.opc(18'h00F80 + 18'(i));
        wr(TLF_REG_RDPTR, 16'h0);
        for (int i = 0; i < 64; i++) begin
            rdline(ln);
            if (i == 0) `CHECK_EQ(ln, 20'h00040)
            if (i == 62) `CHECK_EQ(ln, 20'hC3081)
            if (i == 63) `CHECK_EQ(ln, 20'h00F84)
        end
        $display("test compressed wrap done");
        // clock enable low: a record is not stored
        start(TLF_MODE_NORMAL);
        CE <= 1'b0;
        tlf_cpu_model_i.cof(18'h00123, 1'b0, 1'b0);
        CE <= 1'b1;
        rd(TLF_REG_COUNT, d);
        `CHECK_EQ(d, 16'h0)
        $display("test clock enable done");
        summarize();
    end
endmodule // tb_trace_line_formatter
